// ===== verilog/io_space_pkg.sv
/*
 * constants for the low i/o space decoder: address map, op codes, widths.
 * assumes a core that presents one access per cycle on ref_clk.
 */
`default_nettype none
package io_space_pkg;
    localparam int DATA_W = 8;
    localparam int IO_AW = 6;
    localparam int MEM_AW = 8;
    localparam logic [MEM_AW-1:0] IO_TO_DATA = 8'h20;
    localparam logic [MEM_AW-1:0] EXT_LO = 8'h60;
    localparam logic [MEM_AW-1:0] BIT_IO_HI = 8'h1F;
    localparam logic [MEM_AW-1:0] IO_HI = 8'h3F;
    localparam logic [IO_AW-1:0] ADR_PIN_B = 6'h03;
    localparam logic [IO_AW-1:0] ADR_DIR_B = 6'h04;
    localparam logic [IO_AW-1:0] ADR_OUT_B = 6'h05;
    localparam logic [IO_AW-1:0] ADR_PIN_C = 6'h06;
    localparam logic [IO_AW-1:0] ADR_DIR_C = 6'h07;
    localparam logic [IO_AW-1:0] ADR_OUT_C = 6'h08;
    localparam logic [IO_AW-1:0] ADR_PIN_D = 6'h09;
    localparam logic [IO_AW-1:0] ADR_DIR_D = 6'h0A;
    localparam logic [IO_AW-1:0] ADR_OUT_D = 6'h0B;
    localparam logic [DATA_W-1:0] PORT_C_MASK = 8'h7F;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    // one entry per kind of access the core can issue
    typedef enum logic [2:0]
    {
        OP_NONE,
        OP_PORT_READ,
        OP_PORT_WRITE,
        OP_MEM_READ,
        OP_MEM_WRITE,
        OP_BIT_SET,
        OP_BIT_CLEAR,
        OP_BIT_TEST
    } io_op_t;
endpackage : io_space_pkg
`default_nettype wire

// ===== verilog/io_addr_map.sv
/*
 * address translation: turns a core access into an i/o index and legality.
 * assumes purely combinational use inside the decoder on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module io_addr_map
    import io_space_pkg::*;
(
    // access from the core
    input wire io_op_t op,
    input wire logic [MEM_AW-1:0] addr,
    // decoded result
    output logic [IO_AW-1:0] io_index,
    output logic in_io,
    output logic ext_hit
);
    logic [MEM_AW-1:0] data_off;

    // data-space accesses see i/o at +0x20, short forms see it raw
    always_comb
    begin
        data_off = addr - IO_TO_DATA;
        io_index = addr[IO_AW-1:0];
        in_io = 1'b0;
        ext_hit = 1'b0;
        case (op)
            OP_PORT_READ, OP_PORT_WRITE:
            begin
                in_io = (addr <= IO_HI);
            end
            OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_TEST:
            begin
                in_io = (addr <= BIT_IO_HI);
            end
            OP_MEM_READ, OP_MEM_WRITE:
            begin
                io_index = data_off[IO_AW-1:0];
                in_io = (addr >= IO_TO_DATA) && (addr < EXT_LO);
                ext_hit = (addr >= EXT_LO);
            end
            default:
            begin
                in_io = 1'b0;
            end
        endcase
    end
endmodule : io_addr_map
`default_nettype wire

// ===== verilog/io_space_decode_ports.sv
/*
 * low i/o space decoder holding the port b/c/d pin, direction and output
 * registers, reached by bit ops, short port ops and data-space load/store.
 * assumes the core holds op, addr, bit_sel and wdata stable for one cycle;
 * pin levels come from the pads and are synchronised here.
 */
// Function
// - bit set/clear only on addresses 0x00-0x1F
// - skip tests sample one selected bit
// - bit ops change only the chosen bit
// - write-one clears flag, zero leaves it
// - short port ops use 6-bit address 0x00-0x3F
// - data-space address is i/o address plus 0x20
// - extended space answers load/store only
`timescale 1ns/100ps
`default_nettype none
module io_space_decode_ports
    import io_space_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // access from the core
    input wire io_op_t op,
    input wire logic [MEM_AW-1:0] addr,
    input wire logic [2:0] bit_sel,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata,
    output logic bit_value,
    output logic skip_taken,
    output logic ext_sel,
    // pads
    input wire logic [DATA_W-1:0] pin_b,
    input wire logic [DATA_W-1:0] pin_c,
    input wire logic [DATA_W-1:0] pin_d,
    output logic [DATA_W-1:0] dir_b,
    output logic [DATA_W-1:0] dir_c,
    output logic [DATA_W-1:0] dir_d,
    output logic [DATA_W-1:0] out_b,
    output logic [DATA_W-1:0] out_c,
    output logic [DATA_W-1:0] out_d,
    // flag hook for write-one-to-clear status bits
    input wire logic [DATA_W-1:0] flag_set,
    output logic [DATA_W-1:0] flag_status
);
    localparam logic [IO_AW-1:0] ADR_FLAG = 6'h0C;
    localparam int NREG = 7;

    // every check below lives on the core clock and sleeps in reset
    default clocking io_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic [IO_AW-1:0] io_index;
    logic in_io;
    logic ext_hit;
    logic [DATA_W-1:0] regs [NREG];
    logic [DATA_W-1:0] next_regs [NREG];
    logic [DATA_W-1:0] flags;
    logic [DATA_W-1:0] next_flags;
    logic [DATA_W-1:0] sync1 [3];
    logic [DATA_W-1:0] sync2 [3];
    logic [DATA_W-1:0] cur;
    logic [DATA_W-1:0] next_rdata;
    logic next_bit_value;
    logic next_skip;
    logic next_ext;
    logic wr;
    logic [DATA_W-1:0] wval;
    logic [DATA_W-1:0] bmask;
    logic [IO_AW-1:0] reg_adr [NREG];
    logic [DATA_W-1:0] reg_mask [NREG];

    assign reg_adr[0] = ADR_DIR_B;
    assign reg_adr[1] = ADR_OUT_B;
    assign reg_adr[2] = ADR_DIR_C;
    assign reg_adr[3] = ADR_OUT_C;
    assign reg_adr[4] = ADR_DIR_D;
    assign reg_adr[5] = ADR_OUT_D;
    assign reg_adr[6] = ADR_FLAG;
    assign reg_mask[0] = 8'hFF;
    assign reg_mask[1] = 8'hFF;
    assign reg_mask[2] = PORT_C_MASK;
    assign reg_mask[3] = PORT_C_MASK;
    assign reg_mask[4] = 8'hFF;
    assign reg_mask[5] = 8'hFF;
    assign reg_mask[6] = ZERO_BYTE;

    io_addr_map u_map
    (
        .op(op),
        .addr(addr),
        .io_index(io_index),
        .in_io(in_io),
        .ext_hit(ext_hit)
    );

    // pad levels are asynchronous, two stages before anything reads them
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 3; i++)
            begin
                sync1[i] <= ZERO_BYTE;
                sync2[i] <= ZERO_BYTE;
            end
        end
        else
        begin
            sync1[0] <= pin_b;
            sync1[1] <= pin_c;
            sync1[2] <= pin_d;
            for (int i = 0; i < 3; i++)
            begin
                sync2[i] <= sync1[i];
            end
        end
    end

    // read mux over the legal locations; unmapped gives zero
    always_comb
    begin
        cur = ZERO_BYTE;
        if (io_index == ADR_PIN_B)
        begin
            cur = sync2[0];
        end
        else if (io_index == ADR_PIN_C)
        begin
            cur = sync2[1] & PORT_C_MASK;
        end
        else if (io_index == ADR_PIN_D)
        begin
            cur = sync2[2];
        end
        else if (io_index == ADR_FLAG)
        begin
            cur = flags;
        end
        else
        begin
            for (int i = 0; i < NREG - 1; i++)
            begin
                if (io_index == reg_adr[i])
                begin
                    cur = regs[i] & reg_mask[i];
                end
            end
        end
        if (!in_io)
        begin
            cur = ZERO_BYTE;
        end
    end

    // write value: bit ops touch only the chosen bit, others write zero
    always_comb
    begin
        bmask = 8'h01 << bit_sel;
        wr = in_io && (op == OP_PORT_WRITE || op == OP_MEM_WRITE ||
            op == OP_BIT_SET || op == OP_BIT_CLEAR);
        wval = wdata;
        if (op == OP_BIT_SET)
        begin
            wval = bmask;
        end
        else if (op == OP_BIT_CLEAR)
        begin
            wval = ZERO_BYTE;
        end
        for (int i = 0; i < NREG - 1; i++)
        begin
            next_regs[i] = regs[i];
            if (wr && io_index == reg_adr[i])
            begin
                if (op == OP_BIT_SET || op == OP_BIT_CLEAR)
                begin
                    next_regs[i] = ((regs[i] & ~bmask) | (wval & bmask))
                        & reg_mask[i];
                end
                else
                begin
                    next_regs[i] = wval & reg_mask[i];
                end
            end
        end
        next_regs[NREG-1] = ZERO_BYTE;
        // set beats clear in the same cycle; bit set/clear write zero
        // to the other flags, so they stay intact
        next_flags = flags;
        if (wr && io_index == ADR_FLAG)
        begin
            next_flags = flags & ~wval;
        end
        next_flags = next_flags | flag_set;
        next_rdata = rdata;
        if (op == OP_PORT_READ || op == OP_MEM_READ)
        begin
            next_rdata = cur;
        end
        next_bit_value = cur[bit_sel];
        next_skip = (op == OP_BIT_TEST) && in_io && cur[bit_sel];
        next_ext = ext_hit;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                regs[i] <= REG_RESET;
            end
            flags <= REG_RESET;
            rdata <= ZERO_BYTE;
            bit_value <= 1'b0;
            skip_taken <= 1'b0;
            ext_sel <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NREG; i++)
            begin
                regs[i] <= next_regs[i];
            end
            flags <= next_flags;
            rdata <= next_rdata;
            bit_value <= next_bit_value;
            skip_taken <= next_skip;
            ext_sel <= next_ext;
        end
    end

    assign dir_b = regs[0];
    assign out_b = regs[1];
    assign dir_c = regs[2];
    assign out_c = regs[3];
    assign dir_d = regs[4];
    assign out_d = regs[5];
    assign flag_status = flags;

    a_bit_range: assert property (
        (op == OP_BIT_SET && addr > BIT_IO_HI) |=> $stable(out_b))
        else $error("bit op beyond bit range changed a register");
    a_bit_only: assert property (
        (op == OP_BIT_SET && addr == ADR_OUT_B)
        |=> ((out_b & ~(8'h01 << $past(bit_sel))) ==
        ($past(out_b) & ~(8'h01 << $past(bit_sel)))))
        else $error("bit set disturbed other bits");
    a_w1c_flag: assert property (
        (op == OP_PORT_WRITE && addr == ADR_FLAG && flag_set == 8'h00)
        |=> flag_status == ($past(flag_status) & ~$past(wdata)))
        else $error("flag clear wrong");
    a_mem_offset: assert property (
        (op == OP_MEM_WRITE && addr == IO_TO_DATA + 8'(ADR_OUT_B))
        |=> out_b == $past(wdata))
        else $error("data-space store missed port b output");
    a_port_write: assert property (
        (op == OP_PORT_WRITE && addr == ADR_DIR_D) |=> dir_d == $past(wdata))
        else $error("port write missed direction d");
    // short forms and bit ops must never raise the extended select
    a_ext_only: assert property (
        (op != OP_MEM_READ && op != OP_MEM_WRITE) |=> !ext_sel)
        else $error("non load/store access reached extended space");
    a_skip_test: assert property (
        (op == OP_BIT_TEST && addr == ADR_OUT_C && bit_sel == 3'h7)
        |=> !skip_taken)
        else $error("skip on reserved port c bit");
    a_rsvd_zero: assert property (
        (op == OP_PORT_READ && addr == 8'h01) |=> rdata == 8'h00)
        else $error("reserved address read nonzero");
    c_bit_set: cover property (@(posedge ref_clk) op == OP_BIT_SET && in_io);
    c_skip: cover property (@(posedge ref_clk) skip_taken);
    c_ext: cover property (@(posedge ref_clk) ext_sel);
endmodule : io_space_decode_ports
`default_nettype wire

// ===== verif/core_model.sv
/*
 * core side model: one access at a time on the decoder's core port.
 * assumes the bench calls issue() by hierarchy; ref_clk from the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module core_model
    import io_space_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // access to the decoder
    output var io_op_t op,
    output var logic [MEM_AW-1:0] addr,
    output var logic [2:0] bit_sel,
    output var logic [DATA_W-1:0] wdata
);
    initial
    begin
        op = OP_NONE;
        addr = 8'h00;
        bit_sel = 3'h0;
        wdata = 8'h00;
    end

    // drive after a falling edge, hold across exactly one taking edge
    task automatic issue(input io_op_t o, input logic [7:0] a,
        input logic [2:0] b, input logic [7:0] d);
        logic p;
        p = (o == OP_PORT_READ) || (o == OP_PORT_WRITE);
        @(negedge ref_clk);
        op = o;
        addr = p ? {2'b00, a[5:0]} : a;
        bit_sel = b;
        wdata = d;
        @(negedge ref_clk);
        op = OP_NONE;
        addr = ~addr; // released addr and wdata scramble rather than hold
        wdata = ~wdata;
    endtask : issue
endmodule : core_model
`default_nettype wire

// ===== verif/io_space_decode_ports_bench.sv
/*
 * bench for the low i/o decoder: random accesses against a byte model.
 * assumes core_model drives the core port; pads are held random.
 */
`timescale 1ns/100ps
`default_nettype none
module io_space_decode_ports_bench
    import io_space_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    io_op_t op;
    logic [2:0] bit_sel;
    logic [7:0] addr, wdata, rdata, pin_b, pin_c, pin_d, flag_set;
    logic [7:0] dir_b, dir_c, dir_d, out_b, out_c, out_d, flag_status;
    logic bit_value, skip_taken, ext_sel;
    logic [7:0] mdl [0:63];
    logic [31:0] rn = 32'hB4283F81;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    io_space_decode_ports io_space_decode_ports_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .op(op), .addr(addr),
        .bit_sel(bit_sel), .wdata(wdata), .rdata(rdata),
        .bit_value(bit_value), .skip_taken(skip_taken), .ext_sel(ext_sel),
        .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d), .dir_b(dir_b),
        .dir_c(dir_c), .dir_d(dir_d), .out_b(out_b), .out_c(out_c),
        .out_d(out_d), .flag_set(flag_set), .flag_status(flag_status));
    core_model core_model_inst (.ref_clk(ref_clk), .op(op), .addr(addr),
        .bit_sel(bit_sel), .wdata(wdata));

    initial
        forever #4 ref_clk = ~ref_clk;

    // hang guard: about 670 cycles expected
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            report_and_stop();
        end
    end

    function automatic logic [31:0] nxt();
        rn ^= rn << 13;
        rn ^= rn >> 17;
        rn ^= rn << 5;
        return rn;
    endfunction : nxt

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // pin registers follow the pads; port c bit 7 does not exist
    function automatic logic [7:0] exp_rd(input int io);
        case (io)
            3: return pin_b;
            6: return pin_c & 8'h7F;
            9: return pin_d;
            4, 5, 7, 8, 10, 11, 12: return mdl[io];
            default: return 8'h00;
        endcase
    endfunction : exp_rd

    // flag byte at 0x0C clears where ones are written
    task automatic mdl_wr(input int io, input logic [7:0] d);
        if (io == 12)
            mdl[12] = mdl[12] & ~d;
        else if (io inside {4, 5, 10, 11})
            mdl[io] = d;
        else if (io inside {7, 8})
            mdl[io] = d & 8'h7F;
    endtask : mdl_wr

    task automatic chk_pads();
        chk({dir_b, out_b, dir_c, out_c, dir_d, out_d, flag_status},
            {mdl[4], mdl[5], mdl[7], mdl[8], mdl[10], mdl[11], mdl[12]});
    endtask : chk_pads

    initial
    begin
        int io;
        logic [31:0] r;
        logic [7:0] a, e, m;
        logic [2:0] b;
        r = nxt();
        pin_b = r[7:0];
        pin_c = r[15:8];
        pin_d = r[23:16];
        flag_set = 8'h00;
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 64; i++)
        begin
            core_model_inst.issue(OP_PORT_READ, 8'(i), 3'h0, 8'h00);
            chk(rdata, exp_rd(i));
        end
        // writes by both routes; reserved 0x00-0x02 never written
        for (int n = 0; n < 60; n++)
        begin
            r = nxt();
            io = 3 + r[31:8] % 10;
            a = r[7] ? 8'(io) : 8'(io + 32);
            // port c bit 7 is reserved, software keeps it at zero
            e = (io inside {7, 8}) ? r[15:8] & 8'h7F : r[15:8];
            core_model_inst.issue(r[7] ? OP_PORT_WRITE : OP_MEM_WRITE, a,
                3'h0, e);
            mdl_wr(io, e);
            chk_pads();
        end
        // reads over low, mapped and extended data space
        for (int n = 0; n < 60; n++)
        begin
            r = nxt();
            a = {r[9] & r[8], r[6:0]};
            e = (a >= 8'h20 && a < 8'h60) ? exp_rd(a - 8'h20) : 8'h00;
            core_model_inst.issue(OP_MEM_READ, a, 3'h0, 8'h00);
            chk(rdata, e);
            chk(ext_sel, a >= 8'h60);
        end
        // flag pulses mixed with bit ops, some aimed above 0x1F
        for (int n = 0; n < 120; n++)
        begin
            r = nxt();
            io = 3 + r[31:8] % 10;
            b = r[2:0];
            if (!r[6] && io inside {7, 8} && b == 3'h7)
                b = 3'h6;
            m = 8'h01 << b;
            if (r[4])
            begin
                flag_set = r[15:8];
                @(negedge ref_clk);
                flag_set = 8'h00;
                mdl[12] = mdl[12] | r[15:8];
            end
            if (r[6])
            begin
                e = exp_rd(io) & m;
                core_model_inst.issue(OP_BIT_TEST, 8'(io), b, 8'h00);
                chk(skip_taken, e != 8'h00);
                chk(bit_value, e != 8'h00);
            end
            else
            begin
                a = r[3] ? 8'(io + 32) : 8'(io);
                core_model_inst.issue(r[5] ? OP_BIT_SET : OP_BIT_CLEAR, a,
                    b, 8'h00);
                if (!r[3] && io == 12)
                    mdl_wr(12, r[5] ? m : 8'h00);
                else if (!r[3])
                    mdl_wr(io, r[5] ? mdl[io] | m : mdl[io] & ~m);
                chk_pads();
            end
        end
        report_and_stop();
    end
endmodule : io_space_decode_ports_bench
`default_nettype wire
